// ### src/rbm_map.vh
// register map, command codes and timing constants of the ring controller
`ifndef RBM_MAP_VH
`define RBM_MAP_VH
// device register indices reached over the device register port
`define RBM_DEV_CMD 4'h0
`define RBM_DEV_RING_FIRST 4'h1
`define RBM_DEV_RING_END 4'h2
`define RBM_DEV_READ_LIMIT 4'h3
`define RBM_DEV_ISTAT 4'h7
`define RBM_DEV_RSTART_LO 4'h8
`define RBM_DEV_RSTART_HI 4'h9
`define RBM_DEV_RCOUNT_LO 4'ha
`define RBM_DEV_RCOUNT_HI 4'hb
`define RBM_DEV_TXCFG 4'hd
`define RBM_DEV_WRITE_PTR 4'he
// command register values
`define RBM_CMD_HALT 8'h21
`define RBM_CMD_START 8'h22
`define RBM_CMD_RESEND 8'h26
`define RBM_CMD_TXREQ_BIT 2
// interrupt status bits
`define RBM_IS_SENT_BIT 1
`define RBM_IS_FAULT_BIT 3
`define RBM_IS_OVW_BIT 4
// transmit configuration values: the two loopback modes and normal
`define RBM_TXCFG_LOOP1 8'h02
`define RBM_TXCFG_LOOP2 8'h04
`define RBM_TXCFG_NORMAL 8'h00
// own registers on the avalon slave, byte addresses
`define RBM_REG_CTRL 4'h0
`define RBM_REG_STATUS 4'h4
`define RBM_REG_RING 4'h8
`define RBM_REG_PTRS 4'hc
// control register fields
`define RBM_CTRL_INIT_BIT 0
`define RBM_CTRL_RECOVER_BIT 1
`define RBM_CTRL_POP_BIT 2
`define RBM_CTRL_LOOP2_BIT 3
// timing: halt wait of 1.6 ms counted in 100 MHz clock cycles
`define RBM_HALT_WAIT_CYC 18'd160000
`endif

// ### src/rbm_dev_port.v
// single device register access sequencer with a fixed strobe length
`timescale 1ns/1ps
`default_nettype none
module rbm_dev_port (
  input wire clk_i,
  input wire rst_n_i,
  input wire go_i,
  input wire wr_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] dev_rdata_i,
  output reg dev_cs_ff,
  output reg dev_we_ff,
  output reg [3:0] dev_addr_ff,
  output reg [7:0] dev_wdata_ff,
  output reg [7:0] rdata_ff,
  output reg done_ff
);
  reg [1:0] cnt_ff;
  // strobe held four cycles so a slow device sees a stable access
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      dev_cs_ff <= 1'b0;
      dev_we_ff <= 1'b0;
      dev_addr_ff <= 4'h0;
      dev_wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      done_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      done_ff <= 1'b0;
      if (!dev_cs_ff && go_i) begin
        dev_cs_ff <= 1'b1;
        dev_we_ff <= wr_i;
        dev_addr_ff <= addr_i;
        dev_wdata_ff <= wdata_i;
        cnt_ff <= 2'h0;
      end else if (dev_cs_ff) begin
        cnt_ff <= cnt_ff + 2'h1;
        if (cnt_ff == 2'h3) begin
          dev_cs_ff <= 1'b0;
          dev_we_ff <= 1'b0;
          rdata_ff <= dev_rdata_i;
          done_ff <= 1'b1;
        end
      end
    end
  end
endmodule // rbm_dev_port
`default_nettype wire

// ### src/rbm_ring_ctrl.v
// host side controller: ring setup, packet pointer upkeep and overflow recovery
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rbm_map.vh"
// Notes on behaviour
// - recovery saves transmit request then writes 21 hex to halt
// - controller waits at least 1.6 ms after halt, ignoring reset flag
// - both remote byte count registers cleared after the wait
// - resend set only if saved request and neither sent nor fault flag
// - loopback via transmit config bits, restored to normal afterwards
// - 22 hex starts the device and its remote channel in loopback
// - in loopback remove a packet, clear warning, then leave loopback
// - with resend set, clear it and write 26 hex
// - read limit kept at least one page behind write pointer
// - init read limit to ring start, write and read pointer one above
// - ring start page is never programmed to zero
// - after a read, read limit becomes next page minus one, wrapped
module rbm_ring_ctrl (
  input wire clk_i,
  input wire rst_n_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire [7:0] dev_rdata_i,
  output wire dev_cs_o,
  output wire dev_we_o,
  output wire [3:0] dev_addr_o,
  output wire [7:0] dev_wdata_o,
  output reg busy_o,
  output reg resend_o
);
  // sequencer states; every device access passes through S_WAITDONE
  localparam S_IDLE = 5'd0;
  localparam S_INIT_HALT = 5'd1;
  localparam S_INIT_FIRST = 5'd2;
  localparam S_INIT_END = 5'd3;
  localparam S_INIT_LIMIT = 5'd4;
  localparam S_INIT_WPTR = 5'd5;
  localparam S_INIT_START = 5'd6;
  localparam S_RC_RDCMD = 5'd7;
  localparam S_RC_HALT = 5'd8;
  localparam S_RC_WAIT = 5'd9;
  localparam S_RC_CLRLO = 5'd10;
  localparam S_RC_CLRHI = 5'd11;
  localparam S_RC_RDIS = 5'd12;
  localparam S_RC_LOOP = 5'd13;
  localparam S_RC_START = 5'd14;
  localparam S_RC_RSLO = 5'd15;
  localparam S_RC_RSHI = 5'd16;
  localparam S_RC_WAITPOP = 5'd17;
  localparam S_RC_LIMIT = 5'd18;
  localparam S_RC_CLROVW = 5'd19;
  localparam S_RC_NORMAL = 5'd20;
  localparam S_RC_RESEND = 5'd21;
  localparam S_POP_LIMIT = 5'd22;
  localparam S_WAITDONE = 5'd23;

  reg [4:0] state_ff;
  reg [4:0] ret_ff;
  // host-side copies of the ring bounds and pointers
  reg [7:0] first_pg_ff;
  reg [7:0] end_pg_ff;
  reg [7:0] next_pkt_ff;
  reg [7:0] limit_ff;
  reg [7:0] hdr_next_ff;
  reg loop2_ff;
  reg txreq_saved_ff;
  reg pop_pend_ff;
  reg ovf_count_ff;
  reg [17:0] wait_ff;
  reg go_ff;
  reg wr_ff;
  reg [3:0] addr_ff;
  reg [7:0] wdata_ff;
  wire [7:0] port_rdata;
  wire port_done;
  // next page minus one with wrap to ring end minus one
  wire [7:0] hdr_minus1 = hdr_next_ff - 8'h01;
  wire [7:0] limit_calc = (hdr_minus1 < first_pg_ff) ? (end_pg_ff - 8'h01) : hdr_minus1;

  rbm_dev_port u_port (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .go_i(go_ff),
    .wr_i(wr_ff),
    .addr_i(addr_ff),
    .wdata_i(wdata_ff),
    .dev_rdata_i(dev_rdata_i),
    .dev_cs_ff(dev_cs_o),
    .dev_we_ff(dev_we_o),
    .dev_addr_ff(dev_addr_o),
    .dev_wdata_ff(dev_wdata_o),
    .rdata_ff(port_rdata),
    .done_ff(port_done)
  );

  // avalon slave: one-cycle waitrequest then answer, control writes start sequences
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      first_pg_ff <= 8'h01;
      end_pg_ff <= 8'h02;
      loop2_ff <= 1'b0;
      hdr_next_ff <= 8'h00;
    end else begin
      avs_waitrequest_o <= 1'b1;
      // a new request is answered next cycle; read data loaded now stands at that edge
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        if (avs_read_i) begin
          case (avs_address_i)
            `RBM_REG_STATUS: avs_readdata_o <= {22'h0, ovf_count_ff, txreq_saved_ff,
              resend_o, busy_o, state_ff, pop_pend_ff};
            `RBM_REG_RING: avs_readdata_o <= {16'h0, end_pg_ff, first_pg_ff};
            `RBM_REG_PTRS: avs_readdata_o <= {8'h0, limit_ff, next_pkt_ff, hdr_next_ff};
            `RBM_REG_CTRL: avs_readdata_o <= {28'h0, loop2_ff, 3'h0};
            default: avs_readdata_o <= 32'h0000_0000;
          endcase
        end
      end
      // writes land only at the edge where the master samples waitrequest low
      if (avs_write_i && !avs_waitrequest_o) begin
        case (avs_address_i)
          `RBM_REG_CTRL: begin
            loop2_ff <= avs_writedata_i[`RBM_CTRL_LOOP2_BIT];
          end
          `RBM_REG_RING: begin
            if (avs_writedata_i[7:0] != 8'h00) begin
              first_pg_ff <= avs_writedata_i[7:0];
            end
            end_pg_ff <= avs_writedata_i[15:8];
          end
          `RBM_REG_PTRS: begin
            hdr_next_ff <= avs_writedata_i[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // control write strobe, aligned with the register writes above
  wire ctrl_wr = avs_write_i && !avs_waitrequest_o && (avs_address_i == `RBM_REG_CTRL);

  // sequencer: each device access is issued then awaited in S_WAITDONE
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= S_IDLE;
      ret_ff <= S_IDLE;
      go_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= 4'h0;
      wdata_ff <= 8'h00;
      next_pkt_ff <= 8'h00;
      limit_ff <= 8'h00;
      txreq_saved_ff <= 1'b0;
      resend_o <= 1'b0;
      busy_o <= 1'b0;
      pop_pend_ff <= 1'b0;
      ovf_count_ff <= 1'b0;
      wait_ff <= 18'h0;
    end else begin
      go_ff <= 1'b0;
      case (state_ff)
        // init beats recover, which beats a pending pop
        S_IDLE: begin
          busy_o <= 1'b0;
          if (ctrl_wr && avs_writedata_i[`RBM_CTRL_INIT_BIT]) begin
            busy_o <= 1'b1;
            state_ff <= S_INIT_HALT;
          end else if (ctrl_wr && avs_writedata_i[`RBM_CTRL_RECOVER_BIT]) begin
            busy_o <= 1'b1;
            ovf_count_ff <= 1'b1;
            state_ff <= S_RC_RDCMD;
          end else if (pop_pend_ff) begin
            busy_o <= 1'b1;
            pop_pend_ff <= 1'b0;
            state_ff <= S_POP_LIMIT;
          end
        end
        // init halts first so ring registers change while the device is idle
        S_INIT_HALT: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_CMD; wdata_ff <= `RBM_CMD_HALT;
          ret_ff <= S_INIT_FIRST; state_ff <= S_WAITDONE;
        end
        // ring bounds follow the values software loaded
        S_INIT_FIRST: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_RING_FIRST; wdata_ff <= first_pg_ff;
          ret_ff <= S_INIT_END; state_ff <= S_WAITDONE;
        end
        S_INIT_END: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_RING_END; wdata_ff <= end_pg_ff;
          ret_ff <= S_INIT_LIMIT; state_ff <= S_WAITDONE;
        end
        S_INIT_LIMIT: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_READ_LIMIT; wdata_ff <= first_pg_ff;
          limit_ff <= first_pg_ff;
          ret_ff <= S_INIT_WPTR; state_ff <= S_WAITDONE;
        end
        S_INIT_WPTR: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_WRITE_PTR;
          wdata_ff <= first_pg_ff + 8'h01;
          next_pkt_ff <= first_pg_ff + 8'h01;
          ret_ff <= S_INIT_START; state_ff <= S_WAITDONE;
        end
        // init ends by starting the device
        S_INIT_START: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_CMD; wdata_ff <= `RBM_CMD_START;
          ret_ff <= S_IDLE; state_ff <= S_WAITDONE;
        end
        S_RC_RDCMD: begin
          go_ff <= 1'b1; wr_ff <= 1'b0; addr_ff <= `RBM_DEV_CMD;
          ret_ff <= S_RC_HALT; state_ff <= S_WAITDONE;
        end
        S_RC_HALT: begin
          txreq_saved_ff <= port_rdata[`RBM_CMD_TXREQ_BIT];
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_CMD; wdata_ff <= `RBM_CMD_HALT;
          wait_ff <= 18'h0;
          ret_ff <= S_RC_WAIT; state_ff <= S_WAITDONE;
        end
        S_RC_WAIT: begin
          wait_ff <= wait_ff + 18'h1;
          if (wait_ff == `RBM_HALT_WAIT_CYC - 18'd1) begin
            state_ff <= S_RC_CLRLO;
          end
        end
        S_RC_CLRLO: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_RCOUNT_LO; wdata_ff <= 8'h00;
          ret_ff <= S_RC_CLRHI; state_ff <= S_WAITDONE;
        end
        S_RC_CLRHI: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_RCOUNT_HI; wdata_ff <= 8'h00;
          ret_ff <= S_RC_RDIS; state_ff <= S_WAITDONE;
        end
        // status read feeds the resend decision
        S_RC_RDIS: begin
          go_ff <= 1'b1; wr_ff <= 1'b0; addr_ff <= `RBM_DEV_ISTAT;
          ret_ff <= S_RC_LOOP; state_ff <= S_WAITDONE;
        end
        S_RC_LOOP: begin
          resend_o <= txreq_saved_ff && !port_rdata[`RBM_IS_SENT_BIT]
            && !port_rdata[`RBM_IS_FAULT_BIT];
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_TXCFG;
          wdata_ff <= loop2_ff ? `RBM_TXCFG_LOOP2 : `RBM_TXCFG_LOOP1;
          ret_ff <= S_RC_START; state_ff <= S_WAITDONE;
        end
        S_RC_START: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_CMD; wdata_ff <= `RBM_CMD_START;
          ret_ff <= S_RC_RSLO; state_ff <= S_WAITDONE;
        end
        // read pointer into remote start; page is upper byte
        S_RC_RSLO: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_RSTART_LO; wdata_ff <= 8'h00;
          ret_ff <= S_RC_RSHI; state_ff <= S_WAITDONE;
        end
        // high byte of remote start carries the page
        S_RC_RSHI: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_RSTART_HI; wdata_ff <= next_pkt_ff;
          ret_ff <= S_RC_WAITPOP; state_ff <= S_WAITDONE;
        end
        // software reads a packet then sets pop
        S_RC_WAITPOP: begin
          if (pop_pend_ff) begin
            pop_pend_ff <= 1'b0;
            state_ff <= S_RC_LIMIT;
          end
        end
        // advance read limit; stays behind write pointer
        S_RC_LIMIT: begin
          next_pkt_ff <= hdr_next_ff;
          limit_ff <= limit_calc;
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_READ_LIMIT; wdata_ff <= limit_calc;
          ret_ff <= S_RC_CLROVW; state_ff <= S_WAITDONE;
        end
        S_RC_CLROVW: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_ISTAT;
          wdata_ff <= 8'h01 << `RBM_IS_OVW_BIT;
          ret_ff <= S_RC_NORMAL; state_ff <= S_WAITDONE;
        end
        S_RC_NORMAL: begin
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_TXCFG; wdata_ff <= `RBM_TXCFG_NORMAL;
          ret_ff <= resend_o ? S_RC_RESEND : S_IDLE; state_ff <= S_WAITDONE;
        end
        // clear resend and write 26 hex
        S_RC_RESEND: begin
          resend_o <= 1'b0;
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_CMD; wdata_ff <= `RBM_CMD_RESEND;
          ret_ff <= S_IDLE; state_ff <= S_WAITDONE;
        end
        S_POP_LIMIT: begin
          next_pkt_ff <= hdr_next_ff;
          limit_ff <= limit_calc;
          go_ff <= 1'b1; wr_ff <= 1'b1; addr_ff <= `RBM_DEV_READ_LIMIT; wdata_ff <= limit_calc;
          ret_ff <= S_IDLE; state_ff <= S_WAITDONE;
        end
        // the port pulses done once its strobe has ended
        S_WAITDONE: begin
          if (port_done) begin
            state_ff <= ret_ff;
          end
        end
        // unused codes fall back to idle
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
      // pop request is sticky; placed last so a new pop beats a same-cycle consume
      if (ctrl_wr && avs_writedata_i[`RBM_CTRL_POP_BIT]) begin
        pop_pend_ff <= 1'b1;
      end
    end
  end
endmodule // rbm_ring_ctrl
`default_nettype wire

// ### bench/rbm_ring_ctrl_monitor.sv
// assertions on the ring controller ports
`timescale 1ns/1ps
`default_nettype none
`include "rbm_map.vh"
module rbm_mon (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic dev_cs_o,
  input wire logic dev_we_o,
  input wire logic [3:0] dev_addr_o,
  input wire logic [7:0] dev_wdata_o,
  input wire logic busy_o,
  input wire logic resend_o
);
  logic cs_q_ff;
  logic [17:0] halt_cnt_ff;
  logic halt_wr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // halt write seen only at the start of its strobe
  assign halt_wr = dev_cs_o && !cs_q_ff && dev_we_o && dev_addr_o == `RBM_DEV_CMD
    && dev_wdata_o == `RBM_CMD_HALT;
  // cycles since halt, saturating so a long idle cannot wrap into a false fail
  always_ff @(posedge clk_i) begin
    cs_q_ff <= rst_n_i && dev_cs_o;
    if (!rst_n_i || halt_wr) begin
      halt_cnt_ff <= 18'h0;
    end else if (halt_cnt_ff != 18'h3ffff) begin
      halt_cnt_ff <= halt_cnt_ff + 18'h1;
    end
  end
  // one device access: four strobe cycles, then a gap of two
  sequence s_strobe;
    dev_cs_o [*4] ##1 !dev_cs_o;
  endsequence
  sequence s_gap;
    !dev_cs_o [*2];
  endsequence
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered next cycle");
  a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  a_strobe_len: assert property ($rose(dev_cs_o) |-> s_strobe)
    else $error("device strobe not four cycles");
  a_strobe_gap: assert property ($fell(dev_cs_o) |-> s_gap)
    else $error("device accesses too close");
  a_strobe_stable: assert property (dev_cs_o && $past(dev_cs_o)
    |-> $stable(dev_addr_o) && $stable(dev_we_o) && $stable(dev_wdata_o))
    else $error("device access changed under strobe");
  a_we_in_cs: assert property (dev_we_o |-> dev_cs_o) else $error("write strobe without select");
  a_halt_wait: assert property ($rose(dev_cs_o) && dev_addr_o == `RBM_DEV_RCOUNT_LO
    |-> halt_cnt_ff >= `RBM_HALT_WAIT_CYC) else $error("count clear too soon after halt");
  a_halt_busy: assert property (halt_wr |-> busy_o) else $error("halt outside a sequence");
  a_first_nonzero: assert property (dev_we_o && dev_addr_o == `RBM_DEV_RING_FIRST
    |-> dev_wdata_o != 8'h00) else $error("ring start written as zero");
  a_resend_busy: assert property ($rose(resend_o) |-> busy_o)
    else $error("resend set outside recovery");
endmodule // rbm_mon
bind rbm_ring_ctrl rbm_mon i_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .dev_cs_o(dev_cs_o), .dev_we_o(dev_we_o),
  .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .busy_o(busy_o), .resend_o(resend_o));
`default_nettype wire

// ### bench/rbm_dev_model.sv
// behavioural device register file on the controller's register port
`timescale 1ns/1ps
`default_nettype none
`include "rbm_map.vh"
module rbm_dev_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dev_cs_i,
  input wire logic dev_we_i,
  input wire logic [3:0] dev_addr_i,
  input wire logic [7:0] dev_wdata_i,
  output logic [7:0] dev_rdata_o
);
  logic [7:0] regs [16];
  logic [7:0] last_ff;
  logic cs_q_ff;
  logic [7:0] hdr_next_pg;
  logic [11:0] wlog [$];
  int cyc;
  int halt_cyc;
  int clr_cyc;
  // no pull-up: an idle bus shows the inverse of the last value
  assign dev_rdata_o = dev_cs_i ? regs[dev_addr_i] : ~last_ff;
  // writes commit once, at the first strobe cycle
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    cs_q_ff <= dev_cs_i;
    if (dev_cs_i) last_ff <= regs[dev_addr_i];
    if (!rst_n_i) begin
      for (int i = 0; i < 16; i++) regs[i] <= 8'h00;
      regs[`RBM_DEV_CMD] <= `RBM_CMD_RESEND;
    end else if (dev_cs_i && dev_we_i && !cs_q_ff) begin
      wlog.push_back({dev_addr_i, dev_wdata_i});
      if (dev_addr_i == `RBM_DEV_CMD && dev_wdata_i == `RBM_CMD_HALT) halt_cyc <= cyc;
      if (dev_addr_i == `RBM_DEV_RCOUNT_LO) clr_cyc <= cyc;
      // halt, start, loopback taken at once
      if (dev_addr_i == `RBM_DEV_ISTAT) regs[dev_addr_i] <= regs[dev_addr_i] & ~dev_wdata_i;
      // the transmit request bit, once set, stays set through every later command write
      else if (dev_addr_i == `RBM_DEV_CMD)
        regs[dev_addr_i] <= dev_wdata_i | (regs[dev_addr_i] & (8'h01 << `RBM_CMD_TXREQ_BIT));
      else regs[dev_addr_i] <= dev_wdata_i;
    end
  end
  // one arriving frame of len data bytes, stored from the write pointer
  task automatic rx_pkt(input int len, input logic good);
    int pages;
    logic [7:0] pg;
    logic abort;
    // four header bytes, data, four check bytes
    pages = (len + 8 + 255) / 256;
    pg = regs[`RBM_DEV_WRITE_PTR];
    abort = 1'b0;
    // link page by page; wrap; stop at read limit
    for (int i = 1; i < pages; i++) begin
      pg = pg + 8'h01;
      if (pg == regs[`RBM_DEV_RING_END]) pg = regs[`RBM_DEV_RING_FIRST];
      if (pg == regs[`RBM_DEV_READ_LIMIT]) abort = 1'b1;
    end
    pg = pg + 8'h01;
    if (pg == regs[`RBM_DEV_RING_END]) pg = regs[`RBM_DEV_RING_FIRST];
    @(posedge clk_i);
    // only this frame is lost and the warning is raised
    if (abort) regs[`RBM_DEV_ISTAT] <= regs[`RBM_DEV_ISTAT] | (8'h01 << `RBM_IS_OVW_BIT);
    // header names the next free page; rejects keep it
    else if (good) begin
      hdr_next_pg <= pg;
      regs[`RBM_DEV_WRITE_PTR] <= pg;
    end
    @(posedge clk_i);
  endtask
endmodule // rbm_dev_model
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench: ring controller against a device model
`timescale 1ns/1ps
`default_nettype none
`include "rbm_map.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o;
  wire [7:0] dev_rdata_i;
  wire dev_cs_o;
  wire dev_we_o;
  wire [3:0] dev_addr_o;
  wire [7:0] dev_wdata_o;
  wire busy_o;
  wire resend_o;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [15:0] pops [2] = '{16'h405f, 16'h4544};
  logic [11:0] exp_log [11] = '{{`RBM_DEV_CMD, `RBM_CMD_HALT}, {`RBM_DEV_RCOUNT_LO, 8'h00},
    {`RBM_DEV_RCOUNT_HI, 8'h00}, {`RBM_DEV_TXCFG, `RBM_TXCFG_LOOP2}, {`RBM_DEV_CMD, `RBM_CMD_START},
    {`RBM_DEV_RSTART_LO, 8'h00}, {`RBM_DEV_RSTART_HI, 8'h45}, {`RBM_DEV_READ_LIMIT, 8'h46},
    {`RBM_DEV_ISTAT, 8'h10}, {`RBM_DEV_TXCFG, `RBM_TXCFG_NORMAL}, {`RBM_DEV_CMD, `RBM_CMD_RESEND}};
  rbm_ring_ctrl i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .dev_rdata_i(dev_rdata_i), .dev_cs_o(dev_cs_o), .dev_we_o(dev_we_o), .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o), .busy_o(busy_o), .resend_o(resend_o));
  rbm_dev_model i_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_cs_i(dev_cs_o), .dev_we_i(dev_we_o),
    .dev_addr_i(dev_addr_o), .dev_wdata_i(dev_wdata_o), .dev_rdata_o(dev_rdata_i));
  // free-running 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic conclude;
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    chk({31'h0, avs_waitrequest_o}, 32'h0);
  endtask
  // busy may take a cycle to rise; the fall wait covers the full halt delay
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (busy_o !== 1'b0 && n < 200000) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, busy_o}, 32'h0);
  endtask
  initial begin
    int n;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, `RBM_REG_RING, 32'h0);
    chk(rd, 32'h0000_0201);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `RBM_REG_RING, 32'h0000_6040);
    bus(1'b1, `RBM_REG_RING, 32'h0000_6000);
    bus(1'b0, `RBM_REG_RING, 32'h0);
    chk(rd, 32'h0000_6040);
    bus(1'b1, `RBM_REG_CTRL, 32'h1);
    wait_idle();
    chk8(i_dev.regs[`RBM_DEV_RING_FIRST], 8'h40);
    chk8(i_dev.regs[`RBM_DEV_RING_END], 8'h60);
    chk8(i_dev.regs[`RBM_DEV_READ_LIMIT], 8'h40);
    chk8(i_dev.regs[`RBM_DEV_WRITE_PTR], 8'h41);
    bus(1'b0, `RBM_REG_PTRS, 32'h0);
    chk8(rd[15:8], 8'h41);
    // a long frame fills pages 41 to 5c
    i_dev.rx_pkt(7000, 1'b1);
    chk8(i_dev.regs[`RBM_DEV_WRITE_PTR], 8'h5d);
    chk8(i_dev.hdr_next_pg, 8'h5d);
    // wrapped and plain read-limit updates after a packet is removed
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `RBM_REG_PTRS, {24'h0, pops[i][15:8]});
      bus(1'b1, `RBM_REG_CTRL, 32'h4);
      wait_idle();
      bus(1'b0, `RBM_REG_PTRS, 32'h0);
      chk({8'h0, rd[23:0]}, {8'h0, pops[i][7:0], pops[i][15:8], pops[i][15:8]});
      chk8(i_dev.regs[`RBM_DEV_READ_LIMIT], pops[i][7:0]);
    end
    // wrap past ring end, a rejected frame, then a frame that meets the read limit
    i_dev.rx_pkt(900, 1'b1);
    chk8(i_dev.regs[`RBM_DEV_WRITE_PTR], 8'h41);
    chk8(i_dev.hdr_next_pg, 8'h41);
    i_dev.rx_pkt(100, 1'b0);
    chk8(i_dev.regs[`RBM_DEV_WRITE_PTR], 8'h41);
    i_dev.rx_pkt(900, 1'b1);
    chk8(i_dev.regs[`RBM_DEV_WRITE_PTR], 8'h41);
    chk8(i_dev.regs[`RBM_DEV_ISTAT], 8'h10);
    // overflow recovery in mode 2 with a transmit lost at the halt
    i_dev.wlog.delete();
    bus(1'b1, `RBM_REG_CTRL, 32'ha);
    n = 0;
    while (i_dev.wlog.size() < 7 && n < 200000) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, resend_o}, 32'h1);
    bus(1'b1, `RBM_REG_PTRS, 32'h47);
    bus(1'b1, `RBM_REG_CTRL, 32'hc);
    wait_idle();
    chk({31'h0, resend_o}, 32'h0);
    chk(i_dev.wlog.size(), 32'd11);
    for (int i = 0; i < 11; i++)
      chk({20'h0, i_dev.wlog[i]}, {20'h0, exp_log[i]});
    chk({31'h0, i_dev.clr_cyc - i_dev.halt_cyc >= `RBM_HALT_WAIT_CYC}, 32'h1);
    chk8(i_dev.regs[`RBM_DEV_ISTAT] & 8'h10, 8'h00);
    bus(1'b0, `RBM_REG_STATUS, 32'h0);
    chk({30'h0, rd[9:8]}, 32'h3);
    conclude();
  end
  // watchdog: the halt wait alone is 160000 cycles
  initial begin
    #3000000;
    fails++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
